// file: rtl/ssc_pkg.sv
`default_nettype none

package ssc_pkg;

	// ----------------------------------------------------------------
	// register indices; byte address on the bus is four times the index
	// ----------------------------------------------------------------
	localparam logic [15:0] SIGNAL_STRENGTH_CONFIG_IDX = 16'hFF4C;
	localparam logic [15:0] SIGNAL_STRENGTH_STATUS_IDX = 16'hFF4F;
	localparam logic [15:0] EVENT_STATUS_IDX           = 16'hFF40;
	localparam logic [15:0] EVENT_MASK_IDX             = 16'hFF41;
	localparam int          ADDR_W                     = 18;

	// ----------------------------------------------------------------
	// config field positions
	// ----------------------------------------------------------------
	localparam int CFG_CONT_BIT   = 0;
	localparam int CFG_TXSEL_BIT  = 1;
	localparam int CFG_ENHANC_BIT = 2;
	localparam int CFG_W          = 3;

	// ----------------------------------------------------------------
	// status field positions
	// ----------------------------------------------------------------
	localparam int STAT_RXREQ_BIT = 7;
	localparam int STAT_MID_BIT   = 6;
	localparam int STAT_TXREQ_BIT = 5;
	localparam int CODE_W         = 5;

	// ----------------------------------------------------------------
	// event bits of the interrupt status and mask registers
	// ----------------------------------------------------------------
	localparam int EV_RX_DONE_BIT = 0;
	localparam int EV_TX_DONE_BIT = 1;
	localparam int EV_W           = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [CFG_W-1:0]  CFG_RESET  = 3'h0;
	localparam logic [CODE_W-1:0] CODE_RESET = 5'h00;
	localparam logic [EV_W-1:0]   EV_RESET   = 2'h0;
	localparam logic [31:0]       RDATA_ZERO = 32'h00000000;

	// converter handshake: done pulse with the code it produced
	typedef struct packed {
		logic              done;
		logic [CODE_W-1:0] code;
	} ssc_adc_t;

	// window timing: start-of-window pulses and the async mode level
	typedef struct packed {
		logic rx_start;
		logic tx_start;
		logic async_mode;
	} ssc_win_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01
	} ssc_state_t;

endpackage : ssc_pkg

`default_nettype wire

// file: rtl/ssc_peak.sv
`default_nettype none

// holds the largest code seen since the last clear
module ssc_peak #(
	parameter int W = 5
) (
	input  wire logic         i_sys_clk,
	input  wire logic         i_rstn,
	input  wire logic         i_clear,
	input  wire logic         i_load,
	input  wire logic [W-1:0] i_code,
	output logic      [W-1:0] o_peak_q
);

	logic [W-1:0] peak_d;

	// ----------------------------------------------------------------
	// next peak; clear wins so a fresh request never sees an old peak
	// ----------------------------------------------------------------
	always_comb begin
		peak_d = o_peak_q;
		if (i_clear) begin
			peak_d = '0;
		end else if (i_load && (i_code > o_peak_q)) begin
			peak_d = i_code;
		end
	end

	// register
	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			o_peak_q <= '0;
		end else begin
			o_peak_q <= peak_d;
		end
	end

endmodule : ssc_peak

`default_nettype wire

// file: rtl/ssc_top.sv
// The Avalon-MM register port was left to the implementer.
`default_nettype none

module ssc_top #(
	parameter int CODE_W = 5
) (
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_rstn,
	// avalon-mm slave
	input  wire logic [ssc_pkg::ADDR_W-1:0] i_avs_address,
	input  wire logic                       i_avs_read,
	input  wire logic                       i_avs_write,
	input  wire logic [31:0]                i_avs_writedata,
	input  wire logic [3:0]                 i_avs_byteenable,
	output logic      [31:0]                o_avs_readdata,
	output logic                            o_avs_waitrequest,
	// converter, window timing and port pin
	input  wire ssc_pkg::ssc_adc_t          i_adc,
	input  wire ssc_pkg::ssc_win_t          i_win,
	input  wire logic                       i_general_input_pin,
	output logic                            o_adc_start,
	output logic                            o_irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [ssc_pkg::CFG_W-1:0] cfg_q,       cfg_d;
	logic                      rx_req_q,    rx_req_d;
	logic                      tx_req_q,    tx_req_d;
	logic                      rx_cont_q,   rx_cont_d;
	logic                      tx_cont_q,   tx_cont_d;
	logic                      cur_tx_q,    cur_tx_d;
	logic [CODE_W-1:0]         rx_res_q,    rx_res_d;
	logic [CODE_W-1:0]         tx_res_q,    tx_res_d;
	logic [ssc_pkg::EV_W-1:0]  ev_stat_q,   ev_stat_d;
	logic [ssc_pkg::EV_W-1:0]  ev_mask_q,   ev_mask_d;
	logic [31:0]               rdata_q,     rdata_d;
	logic                      wait_q,      wait_d;
	logic                      start_q,     start_d;
	logic                      irq_q,       irq_d;
	ssc_pkg::ssc_state_t       state_q,     state_d;

	logic                      enh;
	logic                      access;
	logic                      wr_en;
	logic [15:0]               idx;
	logic                      hit_cfg;
	logic                      hit_stat;
	logic                      hit_evs;
	logic                      hit_evm;
	logic                      wr_rxreq;
	logic                      wr_txreq;
	logic                      done_rx;
	logic                      done_tx;
	logic                      rx_pend;
	logic                      tx_pend;
	logic [CODE_W-1:0]         rx_peak;
	logic [CODE_W-1:0]         tx_peak;
	logic [CODE_W-1:0]         shown_code;
	logic [7:0]                stat_view;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// a request is taken on the edge where waitrequest is seen low
	assign idx      = i_avs_address[ssc_pkg::ADDR_W-1:2];
	assign access   = (i_avs_read || i_avs_write) && !wait_q;
	assign wr_en    = access && i_avs_write && i_avs_byteenable[0];
	assign hit_cfg  = (idx == ssc_pkg::SIGNAL_STRENGTH_CONFIG_IDX);
	assign hit_stat = (idx == ssc_pkg::SIGNAL_STRENGTH_STATUS_IDX);
	assign hit_evs  = (idx == ssc_pkg::EVENT_STATUS_IDX);
	assign hit_evm  = (idx == ssc_pkg::EVENT_MASK_IDX);

	// mode and request writes
	assign enh      = cfg_q[ssc_pkg::CFG_ENHANC_BIT];
	assign wr_rxreq = wr_en && hit_stat && i_avs_writedata[ssc_pkg::STAT_RXREQ_BIT];
	assign wr_txreq = wr_en && hit_stat && enh
	                  && i_avs_writedata[ssc_pkg::STAT_TXREQ_BIT];

	// completion of the conversion in flight
	assign done_rx  = (state_q == ssc_pkg::ST_CONV) && i_adc.done && !cur_tx_q;
	assign done_tx  = (state_q == ssc_pkg::ST_CONV) && i_adc.done && cur_tx_q;

	// continuous mode keeps a window pending after the first result
	assign rx_pend  = rx_req_q || rx_cont_q;
	assign tx_pend  = tx_req_q || tx_cont_q;

	// ----------------------------------------------------------------
	// peak holders, one per window
	// ----------------------------------------------------------------
	ssc_peak #(
		.W        (CODE_W)
	) u_rx_peak (
		.i_sys_clk(i_sys_clk),
		.i_rstn   (i_rstn),
		.i_clear  (wr_rxreq),
		.i_load   (done_rx),
		.i_code   (i_adc.code),
		.o_peak_q (rx_peak)
	);

	ssc_peak #(
		.W        (CODE_W)
	) u_tx_peak (
		.i_sys_clk(i_sys_clk),
		.i_rstn   (i_rstn),
		.i_clear  (wr_txreq),
		.i_load   (done_tx),
		.i_code   (i_adc.code),
		.o_peak_q (tx_peak)
	);

	// ----------------------------------------------------------------
	// status view
	// ----------------------------------------------------------------
	// async mode in enhanced mode shows the receive peak, else the selected window result
	always_comb begin
		if (enh && i_win.async_mode) begin
			shown_code = rx_peak;
		end else if (cfg_q[ssc_pkg::CFG_TXSEL_BIT]) begin
			shown_code = tx_res_q;
		end else begin
			shown_code = rx_res_q;
		end
		stat_view = 8'h00;
		stat_view[CODE_W-1:0] = shown_code;
		stat_view[ssc_pkg::STAT_RXREQ_BIT] = rx_req_q;
		if (enh) begin
			stat_view[ssc_pkg::STAT_MID_BIT]   = i_win.async_mode;
			stat_view[ssc_pkg::STAT_TXREQ_BIT] = tx_req_q;
		end else begin
			stat_view[ssc_pkg::STAT_MID_BIT]   = i_general_input_pin;
		end
	end

	// ----------------------------------------------------------------
	// bus slave: one wait cycle, then the answer
	// ----------------------------------------------------------------
	// read data are sampled while waitrequest is high so they come from a
	// flop; the value is the state one cycle before the accepting edge
	always_comb begin
		wait_d  = !((i_avs_read || i_avs_write) && wait_q);
		rdata_d = rdata_q;
		if ((i_avs_read || i_avs_write) && wait_q) begin
			rdata_d = ssc_pkg::RDATA_ZERO;
			if (hit_cfg) begin
				rdata_d[ssc_pkg::CFG_W-1:0] = cfg_q;
			end else if (hit_stat) begin
				rdata_d[7:0] = stat_view;
			end else if (hit_evs) begin
				rdata_d[ssc_pkg::EV_W-1:0] = ev_stat_q;
			end else if (hit_evm) begin
				rdata_d[ssc_pkg::EV_W-1:0] = ev_mask_q;
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			wait_q  <= 1'b1;
			rdata_q <= ssc_pkg::RDATA_ZERO;
		end else begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// configuration and continuous flags
	// ----------------------------------------------------------------
	// any write to the config ends a continuous run
	always_comb begin
		cfg_d     = cfg_q;
		rx_cont_d = rx_cont_q;
		tx_cont_d = tx_cont_q;
		if (wr_en && hit_cfg) begin
			cfg_d     = i_avs_writedata[ssc_pkg::CFG_W-1:0];
			rx_cont_d = 1'b0;
			tx_cont_d = 1'b0;
		end else begin
			if (wr_rxreq) begin
				rx_cont_d = cfg_q[ssc_pkg::CFG_CONT_BIT];
			end
			if (wr_txreq) begin
				tx_cont_d = cfg_q[ssc_pkg::CFG_CONT_BIT];
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			cfg_q     <= ssc_pkg::CFG_RESET;
			rx_cont_q <= 1'b0;
			tx_cont_q <= 1'b0;
		end else begin
			cfg_q     <= cfg_d;
			rx_cont_q <= rx_cont_d;
			tx_cont_q <= tx_cont_d;
		end
	end

	// ----------------------------------------------------------------
	// conversion sequencer
	// ----------------------------------------------------------------
	// legacy mode converts at once; enhanced mode waits for the window
	always_comb begin
		state_d  = state_q;
		cur_tx_d = cur_tx_q;
		start_d  = 1'b0;
		case (state_q)
			ssc_pkg::ST_IDLE: begin
				if (rx_pend && (!enh || i_win.rx_start)) begin
					state_d  = ssc_pkg::ST_CONV;
					cur_tx_d = 1'b0;
					start_d  = 1'b1;
				end else if (enh && tx_pend && i_win.tx_start) begin
					state_d  = ssc_pkg::ST_CONV;
					cur_tx_d = 1'b1;
					start_d  = 1'b1;
				end
			end
			ssc_pkg::ST_CONV: begin
				if (i_adc.done) begin
					state_d = ssc_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = ssc_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			state_q  <= ssc_pkg::ST_IDLE;
			cur_tx_q <= 1'b0;
			start_q  <= 1'b0;
		end else begin
			state_q  <= state_d;
			cur_tx_q <= cur_tx_d;
			start_q  <= start_d;
		end
	end

	// ----------------------------------------------------------------
	// request bits and results
	// ----------------------------------------------------------------
	// a request written in the completing cycle wins: the bit stays set
	always_comb begin
		rx_req_d = rx_req_q;
		tx_req_d = tx_req_q;
		rx_res_d = rx_res_q;
		tx_res_d = tx_res_q;
		if (done_rx) begin
			rx_req_d = 1'b0;
			rx_res_d = i_adc.code;
		end
		if (done_tx) begin
			tx_req_d = 1'b0;
			tx_res_d = i_adc.code;
		end
		if (wr_rxreq) begin
			rx_req_d = 1'b1;
			if (enh) begin
				rx_res_d = ssc_pkg::CODE_RESET;
			end
		end
		if (wr_txreq) begin
			tx_req_d = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			rx_req_q <= 1'b0;
			tx_req_q <= 1'b0;
			rx_res_q <= ssc_pkg::CODE_RESET;
			tx_res_q <= ssc_pkg::CODE_RESET;
		end else begin
			rx_req_q <= rx_req_d;
			tx_req_q <= tx_req_d;
			rx_res_q <= rx_res_d;
			tx_res_q <= tx_res_d;
		end
	end

	// ----------------------------------------------------------------
	// completion events and interrupt
	// ----------------------------------------------------------------
	// write one to clear; a completion in the same cycle keeps its bit
	always_comb begin
		ev_stat_d = ev_stat_q;
		ev_mask_d = ev_mask_q;
		if (wr_en && hit_evs) begin
			ev_stat_d = ev_stat_q & ~i_avs_writedata[ssc_pkg::EV_W-1:0];
		end
		if (wr_en && hit_evm) begin
			ev_mask_d = i_avs_writedata[ssc_pkg::EV_W-1:0];
		end
		if (done_rx) begin
			ev_stat_d[ssc_pkg::EV_RX_DONE_BIT] = 1'b1;
		end
		if (done_tx) begin
			ev_stat_d[ssc_pkg::EV_TX_DONE_BIT] = 1'b1;
		end
		irq_d = |(ev_stat_d & ev_mask_d);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			ev_stat_q <= ssc_pkg::EV_RESET;
			ev_mask_q <= ssc_pkg::EV_RESET;
			irq_q     <= 1'b0;
		end else begin
			ev_stat_q <= ev_stat_d;
			ev_mask_q <= ev_mask_d;
			irq_q     <= irq_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from flops
	// ----------------------------------------------------------------
	assign o_avs_readdata    = rdata_q;
	assign o_avs_waitrequest = wait_q;
	assign o_adc_start       = start_q;
	assign o_irq             = irq_q;

endmodule : ssc_top

`default_nettype wire

// file: tb/ssc_top_sva.sv
`default_nettype none

module ssc_top_sva #(
	parameter int CODE_W = 5
) (
	input wire logic                       i_sys_clk,
	input wire logic                       i_rstn,
	input wire logic [ssc_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic                       i_avs_read,
	input wire logic                       i_avs_write,
	input wire logic [31:0]                i_avs_writedata,
	input wire logic [3:0]                 i_avs_byteenable,
	input wire logic [31:0]                o_avs_readdata,
	input wire logic                       o_avs_waitrequest,
	input wire ssc_pkg::ssc_adc_t          i_adc,
	input wire ssc_pkg::ssc_win_t          i_win,
	input wire logic                       i_general_input_pin,
	input wire logic                       o_adc_start,
	input wire logic                       o_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// shadow of mode and busy, from bus writes and the converter done
	// ----------------------------------------------------------------
	logic acc, cfg_wr, st_wr;
	logic enh_q, enh_d, busy_q, busy_d;
	assign acc    = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
	assign cfg_wr = acc && (i_avs_address[17:2] == ssc_pkg::SIGNAL_STRENGTH_CONFIG_IDX);
	assign st_wr  = acc && (i_avs_address[17:2] == ssc_pkg::SIGNAL_STRENGTH_STATUS_IDX);

	// request write wins over a coinciding done
	always_comb begin
		enh_d  = cfg_wr ? i_avs_writedata[ssc_pkg::CFG_ENHANC_BIT] : enh_q;
		busy_d = i_adc.done ? 1'b0 : busy_q;
		if (st_wr && (i_avs_writedata[7] || (enh_q && i_avs_writedata[5]))) begin
			busy_d = 1'b1;
		end
	end

	// shadow registers
	always_ff @(posedge i_sys_clk) begin
		enh_q  <= i_rstn ? enh_d : 1'b0;
		busy_q <= i_rstn ? busy_d : 1'b0;
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_rstn);

	wait_one_a: assert property (
		(i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
		else $error("request not answered after one wait cycle");
	wait_pulse_a: assert property (
		!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low for more than one cycle");
	idle_wait_a: assert property (
		!(i_avs_read || i_avs_write) |=> o_avs_waitrequest)
		else $error("answer without a request");
	start_pulse_a: assert property (
		o_adc_start |=> !o_adc_start)
		else $error("converter start longer than one cycle");
	legacy_start_a: assert property (
		!enh_q && !busy_q && st_wr && i_avs_writedata[7] |-> ##2 o_adc_start)
		else $error("legacy request did not start the converter");
	enh_start_a: assert property (
		enh_q && o_adc_start |-> $past(i_win.rx_start || i_win.tx_start))
		else $error("enhanced start without a window pulse");
	rdata_upper_a: assert property (
		!o_avs_waitrequest |-> (o_avs_readdata[31:8] == 24'h000000))
		else $error("unused read data bits not zero");
	irq_cause_a: assert property (
		$changed(o_irq) |-> $past(i_adc.done || (i_avs_write && !o_avs_waitrequest)))
		else $error("interrupt changed without a cause");
endmodule : ssc_top_sva

bind ssc_top ssc_top_sva #(.CODE_W(CODE_W)) ssc_top_sva_inst (
	.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
	.i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
	.o_avs_waitrequest(o_avs_waitrequest), .i_adc(i_adc), .i_win(i_win),
	.i_general_input_pin(i_general_input_pin), .o_adc_start(o_adc_start), .o_irq(o_irq)
);

`default_nettype wire

// file: tb/ssc_adc_model.sv
`default_nettype none

// converter behind the signal strength pin; i_code stands for the pin voltage
module ssc_adc_model (
	input  wire logic        i_sys_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_start,
	input  wire logic [4:0]  i_code,
	input  wire logic [3:0]  i_lat,
	output var  ssc_pkg::ssc_adc_t o_adc
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] cnt;
	logic       run;
	logic       fire;

	// the conversion ends when the latency count has run out
	assign fire = run && !i_start && (cnt == 4'h0);

	// code toggles outside done so a stale value never looks valid
	always @(posedge i_sys_clk) begin
		if (!i_rstn) begin
			run   <= 1'b0;
			cnt   <= 4'h0;
			o_adc <= '0;
		end else begin
			o_adc.done <= fire;
			o_adc.code <= fire ? i_code : ~o_adc.code;
			if (i_start) begin
				run <= 1'b1;
				cnt <= i_lat;
			end else if (fire) begin
				run <= 1'b0;
			end else if (run) begin
				cnt <= cnt - 4'h1;
			end
		end
	end
endmodule : ssc_adc_model

`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// byte addresses and stimulus
	// ----------------------------------------------------------------
	localparam logic [17:0] A_CFG = {ssc_pkg::SIGNAL_STRENGTH_CONFIG_IDX, 2'b00};
	localparam logic [17:0] A_ST  = {ssc_pkg::SIGNAL_STRENGTH_STATUS_IDX, 2'b00};
	localparam logic [17:0] A_EV  = {ssc_pkg::EVENT_STATUS_IDX, 2'b00};
	localparam logic [17:0] A_MSK = {ssc_pkg::EVENT_MASK_IDX, 2'b00};
	localparam logic [17:0] A_BAD = 18'h3FD08;
	logic              clk, rstn, rd, wr, wreq, pin, adc_start, irq;
	logic [17:0]       addr;
	logic [31:0]       wdata, rdata;
	logic [3:0]        be, lat;
	logic [4:0]        vin;
	ssc_pkg::ssc_win_t win;
	ssc_pkg::ssc_adc_t adc;
	int                fails, samples_checked;
	logic [4:0]        codes [3] = '{5'h00, 5'h1F, 5'h15};

	ssc_top ssc_top_inst (
		.i_sys_clk(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_adc(adc), .i_win(win),
		.i_general_input_pin(pin), .o_adc_start(adc_start), .o_irq(irq)
	);
	ssc_adc_model ssc_adc_model_inst (
		.i_sys_clk(clk), .i_rstn(rstn), .i_start(adc_start), .i_code(vin),
		.i_lat(lat), .o_adc(adc)
	);

	// 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic tally_and_finish();
		if (fails == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// holds the request until waitrequest is sampled low, then releases
	task automatic bus(input logic w, input logic [17:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		@(posedge clk);
		rd    <= !w;
		wr    <= w;
		addr  <= a;
		wdata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wreq !== 1'b0 && n < 50);
		if (n >= 50) begin
			fails++;
			tally_and_finish();
		end
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task automatic wreg(input logic [17:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wreg

	task automatic rdc(input logic [17:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask : rdc

	// irq is registered at the accepting edge, so look one edge later
	task automatic chk_irq(input logic exp);
		@(posedge clk);
		chk({31'h0, irq}, {31'h0, exp});
	endtask : chk_irq

	// software side: poll until the request bit drops
	task automatic poll();
		logic [31:0] q;
		int n;
		n = 0;
		q = 32'hFFFFFFFF;
		while (q[7] !== 1'b0 && n < 40) begin
			bus(1'b0, A_ST, 32'h0, q);
			n++;
		end
		if (n >= 40) begin
			fails++;
			tally_and_finish();
		end
	endtask : poll

	task automatic window(input logic tx);
		int n;
		@(posedge clk);
		win.rx_start <= !tx;
		win.tx_start <= tx;
		@(posedge clk);
		win.rx_start <= 1'b0;
		win.tx_start <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (adc.done !== 1'b1 && n < 40);
		if (n >= 40) begin
			fails++;
			tally_and_finish();
		end
	endtask : window

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0; rd = 1'b0; wr = 1'b0; addr = 18'h0; wdata = 32'h0; be = 4'hF;
		pin = 1'b0; win = '0; vin = 5'h00; lat = 4'h0; fails = 0; samples_checked = 0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		rdc(A_CFG, 32'h0);
		rdc(A_ST, 32'h0);
		wreg(A_BAD, 32'hFF);
		rdc(A_BAD, 32'h0);
		be <= 4'hE;
		wreg(A_CFG, 32'h7);
		be <= 4'hF;
		rdc(A_CFG, 32'h0);
		// legacy single conversions at both code extremes, fast and slow
		for (int i = 0; i < 3; i++) begin
			vin <= codes[i];
			pin <= i[0];
			lat <= 4'(i * 5);
			wreg(A_ST, 32'h80);
			poll();
			rdc(A_ST, {24'h0, 1'b0, i[0], 1'b0, codes[i]});
		end
		pin <= 1'b1;
		wreg(A_MSK, 32'h1);
		wreg(A_CFG, 32'h4);
		wreg(A_ST, 32'h80);
		rdc(A_ST, 32'h80);
		vin <= 5'h0C;
		window(1'b0);
		rdc(A_ST, 32'h0C);
		chk_irq(1'b1);
		rdc(A_EV, 32'h1);
		wreg(A_MSK, 32'h0);
		chk_irq(1'b0);
		wreg(A_MSK, 32'h1);
		chk_irq(1'b1);
		wreg(A_EV, 32'h1);
		chk_irq(1'b0);
		rdc(A_EV, 32'h0);
		// transmit window, then switch the reported window back
		wreg(A_CFG, 32'h6);
		wreg(A_ST, 32'h20);
		rdc(A_ST, 32'h20);
		vin <= 5'h1A;
		lat <= 4'h6;
		window(1'b1);
		rdc(A_ST, 32'h1A);
		rdc(A_EV, 32'h2);
		wreg(A_CFG, 32'h4);
		rdc(A_ST, 32'h0C);
		// continuous: the second window converts again, peak keeps the larger
		wreg(A_CFG, 32'h5);
		wreg(A_ST, 32'h80);
		vin <= 5'h11;
		window(1'b0);
		vin <= 5'h07;
		window(1'b0);
		rdc(A_ST, 32'h07);
		win.async_mode <= 1'b1;
		rdc(A_ST, 32'h51);
		tally_and_finish();
	end
endmodule : tb_top

`default_nettype wire
